/* rtl/cftc_charge_timer_ctrl.sv */
// Purpose: Fast-charge enable, termination and charge timer of the charger
// Assumes: Conditions arrive asynchronously and pass a two-flop synchroniser
// Notes: Avalon-MM slave answers one cycle after a request is raised
//
// Local design decision: register access over Avalon-MM.
module cftc_charge_timer_ctrl #(
  parameter int unsigned TICK_CYCLES = cftc_pkg::CFTC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Avalon-MM register slave
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Analog charger side
  input wire cftc_pkg::cftc_cond_type i_cond,
  output cftc_pkg::cftc_drive_type o_drive
);
  import cftc_pkg::*;

  // Merge a write into a 16-bit register under the byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
    input logic [31:0] wdata, input logic [3:0] be);
    logic [15:0] res;
    res = old_v;
    if (be[0])
    begin
      res[7:0] = wdata[7:0];
    end
    if (be[1])
    begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // Seconds loaded for a timeout code: 60 minutes plus 30 per step
  function automatic logic [14:0] load_seconds(input logic [3:0] code);
    logic [18:0] prod;
    prod = 19'({15'h0, code} + 19'h2) * 19'(CFTC_TIME_STEP_S);
    return prod[14:0];
  endfunction

  // Synchroniser stages; the first is only read by the second
  cftc_cond_type sync1_reg;
  cftc_cond_type cond;
  logic ready_prev_reg;

  // Bus handshake state
  logic wait_reg;
  logic [31:0] rdata_reg;

  // Software-visible fields
  logic ready_flag_reg;
  logic end_flag_reg;
  logic timeout_flag_reg;
  logic [2:0] eoc_sel_reg;
  logic end_act_reg;
  logic quick_en_reg;
  logic backoff_en_reg;
  logic [3:0] timeout_code_reg;
  logic slow_sel_reg;
  logic [3:0] isel_reg;
  logic [1:0] step_sel_reg;
  logic hold_reg;

  // Charger state and timer
  cftc_state_type state_reg;
  cftc_state_type state_next;
  logic done_reg;
  logic [27:0] tick_cnt_reg;
  logic tick_reg;
  logic [14:0] remain_reg;

  // Decoded access and conditions
  logic [7:0] idx;
  logic hit_ok;
  logic wr_go;
  logic rd_go;
  logic wr_ctrl1;
  logic quick_ready;
  logic paused;
  logic detect_on;
  logic eoc_hit;
  logic eoc_stop;
  logic usb_stop;
  logic expired;
  logic stop_now;
  logic en_change;
  logic [15:0] ctrl1_new;
  logic [9:0] eoc_ma;

  // Two-flop synchroniser for all analog conditions; the current value
  // is sampled often, so a torn word only lasts one cycle
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_reg <= '0;
      cond <= '0;
    end
    else
    begin
      sync1_reg <= i_cond;
      cond <= sync1_reg;
    end
  end

  // Word index and access qualifiers
  always_comb
  begin
    idx = i_avs_address[9:2];
    hit_ok = (idx == CFTC_IDX_IRQ_STATUS) || (idx == CFTC_IDX_CTRL_ONE) ||
      (idx == CFTC_IDX_CTRL_TWO) || (idx == CFTC_IDX_CTRL_THREE) ||
      (idx == CFTC_IDX_HOLD_CTRL);
    // Effects happen at the edge where waitrequest is seen low
    wr_go = i_avs_write && !wait_reg;
    rd_go = i_avs_read && !wait_reg;
    wr_ctrl1 = wr_go && (idx == CFTC_IDX_CTRL_ONE);
    ctrl1_new = merge16({3'h0, eoc_sel_reg, 3'h0, end_act_reg,
      quick_en_reg, backoff_en_reg, 4'h0}, i_avs_writedata,
      i_avs_byteenable);
  end

  // Waitrequest is high at rest and drops for one cycle to answer
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wait_reg <= 1'b1;
    end
    else if (wait_reg && (i_avs_read || i_avs_write))
    begin
      wait_reg <= 1'b0;
    end
    else
    begin
      wait_reg <= 1'b1;
    end
  end

  // Read data prepared while waitrequest is high; unmapped reads zero
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_reg <= '0;
    end
    else if (wait_reg && i_avs_read && hit_ok)
    begin
      rdata_reg <= '0;
      case (idx)
        CFTC_IDX_IRQ_STATUS:
        begin
          rdata_reg[CFTC_BIT_READY] <= ready_flag_reg;
          rdata_reg[CFTC_BIT_END] <= end_flag_reg;
          rdata_reg[CFTC_BIT_TIMEOUT] <= timeout_flag_reg;
        end
        CFTC_IDX_CTRL_ONE:
        begin
          rdata_reg[15:0] <= {3'h0, eoc_sel_reg, 3'h0, end_act_reg,
            quick_en_reg, backoff_en_reg, 4'h0};
        end
        CFTC_IDX_CTRL_TWO:
        begin
          rdata_reg[CFTC_POS_STATE +: 2] <= state_reg;
          // Remaining time in 2048 s units, not the written code
          rdata_reg[CFTC_POS_TIMEOUT +: 4] <=
            remain_reg[CFTC_READ_SHIFT +: 4];
          rdata_reg[CFTC_POS_SLOW_SEL] <= slow_sel_reg;
          rdata_reg[CFTC_POS_ISEL +: 4] <= isel_reg;
        end
        CFTC_IDX_CTRL_THREE:
        begin
          rdata_reg[CFTC_POS_STEP +: 2] <= step_sel_reg;
        end
        default:
        begin
          rdata_reg[CFTC_POS_HOLD] <= hold_reg;
        end
      endcase
    end
    else
    begin
      // Cleared at the answering edge, so data stands for one cycle only
      rdata_reg <= '0;
    end
  end

  // Quick-charge conditions and a written change of the quick enable
  always_comb
  begin
    quick_ready = cond.supply_ok && cond.batt_above_min;
    en_change = wr_ctrl1 && quick_ready &&
      (ctrl1_new[CFTC_POS_QUICK_EN] != quick_en_reg);
  end

  // Remember the ready level for edge detection
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ready_prev_reg <= 1'b0;
    end
    else
    begin
      ready_prev_reg <= quick_ready;
    end
  end

  // Sticky status flags; a new event wins over the read that clears
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ready_flag_reg <= 1'b0;
      end_flag_reg <= 1'b0;
      timeout_flag_reg <= 1'b0;
    end
    else
    begin
      if (rd_go && (idx == CFTC_IDX_IRQ_STATUS))
      begin
        ready_flag_reg <= 1'b0;
        end_flag_reg <= 1'b0;
        timeout_flag_reg <= 1'b0;
      end
      if (quick_ready && !ready_prev_reg)
      begin
        ready_flag_reg <= 1'b1;
      end
      if (eoc_hit)
      begin
        end_flag_reg <= 1'b1;
      end
      if (expired)
      begin
        timeout_flag_reg <= 1'b1;
      end
    end
  end

  // Control one; the quick enable is forced low without ready
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      eoc_sel_reg <= CFTC_RST_EOC;
      end_act_reg <= 1'b0;
      quick_en_reg <= 1'b0;
      backoff_en_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctrl1)
      begin
        eoc_sel_reg <= ctrl1_new[CFTC_POS_EOC +: 3];
        end_act_reg <= ctrl1_new[CFTC_POS_END_ACT];
        backoff_en_reg <= ctrl1_new[CFTC_POS_BACKOFF];
      end
      if (!quick_ready)
      begin
        quick_en_reg <= 1'b0;
      end
      else if (wr_ctrl1)
      begin
        quick_en_reg <= ctrl1_new[CFTC_POS_QUICK_EN];
      end
    end
  end

  // Control two, control three and the hold register
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      timeout_code_reg <= CFTC_RST_TIMEOUT;
      slow_sel_reg <= 1'b0;
      isel_reg <= CFTC_RST_ISEL;
      step_sel_reg <= CFTC_RST_STEP;
      hold_reg <= 1'b0;
    end
    else
    begin
      // Each byte lane lands on its own; a full write sets both lanes
      if (wr_go && idx == CFTC_IDX_CTRL_TWO && i_avs_byteenable[1])
      begin
        timeout_code_reg <= i_avs_writedata[CFTC_POS_TIMEOUT +: 4];
      end
      if (wr_go && idx == CFTC_IDX_CTRL_TWO && i_avs_byteenable[0])
      begin
        slow_sel_reg <= i_avs_writedata[CFTC_POS_SLOW_SEL];
        isel_reg <= i_avs_writedata[CFTC_POS_ISEL +: 4];
      end
      if (wr_go && idx == CFTC_IDX_CTRL_THREE && i_avs_byteenable[0])
      begin
        step_sel_reg <= i_avs_writedata[CFTC_POS_STEP +: 2];
      end
      if (wr_go && idx == CFTC_IDX_HOLD_CTRL && i_avs_byteenable[0])
      begin
        hold_reg <= i_avs_writedata[CFTC_POS_HOLD];
      end
    end
  end

  // Termination conditions
  always_comb
  begin
    paused = hold_reg || cond.temp_pause || cond.maxcur_pause;
    eoc_ma = 10'(CFTC_EOC_BASE_MA +
      10'(eoc_sel_reg) * CFTC_EOC_STEP_MA);
    // Choke or the back-off enable can starve current, so detection is off then
    detect_on = !cond.choke_on && !backoff_en_reg;
    eoc_hit = (state_reg != CFTC_OFF) && !paused && detect_on &&
      (cond.current_ma <= eoc_ma);
    eoc_stop = eoc_hit && !end_act_reg;
    usb_stop = (state_reg == CFTC_QUICK) && cond.usb_limit_hit &&
      !backoff_en_reg;
    expired = (state_reg != CFTC_OFF) && (remain_reg == 15'h0);
    stop_now = eoc_stop || usb_stop || expired || cond.fault;
  end

  // Mode selection
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CFTC_OFF:
      begin
        if (!done_reg && cond.slow_ok)
        begin
          state_next = CFTC_SLOW;
        end
      end
      CFTC_SLOW:
      begin
        if (stop_now || !cond.slow_ok)
        begin
          state_next = CFTC_OFF;
        end
        else if (quick_en_reg && quick_ready)
        begin
          // Only the software enable leads into quick charging
          state_next = CFTC_QUICK;
        end
      end
      CFTC_QUICK:
      begin
        if (stop_now)
        begin
          state_next = CFTC_OFF;
        end
        else if (!quick_en_reg || !quick_ready)
        begin
          state_next = CFTC_SLOW;
        end
      end
      default:
      begin
        state_next = CFTC_OFF;
      end
    endcase
  end

  // Mode register and the latch that keeps a finished charge off
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= CFTC_OFF;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg != CFTC_OFF && stop_now)
      begin
        done_reg <= 1'b1;
      end
      else if (wr_ctrl1)
      begin
        done_reg <= 1'b0;
      end
    end
  end

  // Free-running one-second time base, unaffected by bus traffic
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg == 28'(TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 28'h1;
      tick_reg <= 1'b0;
    end
  end

  // Remaining charge time in seconds
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      remain_reg <= load_seconds(CFTC_RST_TIMEOUT);
    end
    else if (state_reg == CFTC_OFF && state_next != CFTC_OFF)
    begin
      remain_reg <= load_seconds(timeout_code_reg);
    end
    else if (en_change && state_reg != CFTC_OFF)
    begin
      remain_reg <= load_seconds(timeout_code_reg);
    end
    else if (state_reg != CFTC_OFF && tick_reg && !paused &&
      remain_reg != 15'h0)
    begin
      // Fallback to slow on lost conditions does not reload; pauses stop the count
      remain_reg <= remain_reg - 15'h1;
    end
  end

  // Drive to the analog side, registered
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_drive <= '0;
    end
    else
    begin
      o_drive.mode <= state_reg;
      if (state_reg == CFTC_QUICK && !paused)
      begin
        o_drive.current_limit_ma <=
          10'(10'(isel_reg) * CFTC_ISEL_STEP_MA);
      end
      else if (state_reg == CFTC_SLOW && !paused)
      begin
        o_drive.current_limit_ma <= slow_sel_reg ? CFTC_SLOW_HI_MA :
          CFTC_SLOW_LO_MA;
      end
      else
      begin
        o_drive.current_limit_ma <= '0;
      end
      o_drive.throttle_active <= (state_reg == CFTC_QUICK) &&
        backoff_en_reg && cond.usb_limit_hit;
      case (step_sel_reg)
        2'b00: o_drive.backoff_step_us <= CFTC_STEP_US_0;
        2'b01: o_drive.backoff_step_us <= CFTC_STEP_US_1;
        2'b10: o_drive.backoff_step_us <= CFTC_STEP_US_2;
        default: o_drive.backoff_step_us <= CFTC_STEP_US_3;
      endcase
    end
  end

  // Bus outputs straight from their flip-flops
  assign o_avs_readdata = rdata_reg;
  assign o_avs_waitrequest = wait_reg;

endmodule

/* rtl/cftc_pkg.sv */
// Purpose: Shared constants and types for the fast-charge timer controller
// Assumes: 200 MHz core clock, Avalon-MM register access with 32-bit data
// Notes: Register indices are multiplied by four to form byte addresses
package cftc_pkg;

  // Core clock rate and the one-second time base of the charge timer
  localparam int unsigned CFTC_CLK_HZ = 200_000_000;
  localparam int unsigned CFTC_TICK_S = 1;
  localparam int unsigned CFTC_TICK_CYCLES = CFTC_CLK_HZ * CFTC_TICK_S;

  // Register indices (byte address is four times the index)
  localparam logic [7:0] CFTC_IDX_IRQ_STATUS = 8'h15;
  localparam logic [7:0] CFTC_IDX_CTRL_ONE = 8'hA8;
  localparam logic [7:0] CFTC_IDX_CTRL_TWO = 8'hA9;
  localparam logic [7:0] CFTC_IDX_CTRL_THREE = 8'hAA;
  localparam logic [7:0] CFTC_IDX_HOLD_CTRL = 8'hAB;

  // Interrupt status bit positions
  localparam int CFTC_BIT_READY = 9;
  localparam int CFTC_BIT_END = 10;
  localparam int CFTC_BIT_TIMEOUT = 11;

  // Control one field positions
  localparam int CFTC_POS_EOC = 10;
  localparam int CFTC_POS_END_ACT = 6;
  localparam int CFTC_POS_QUICK_EN = 5;
  localparam int CFTC_POS_BACKOFF = 4;

  // Control two field positions
  localparam int CFTC_POS_STATE = 12;
  localparam int CFTC_POS_TIMEOUT = 8;
  localparam int CFTC_POS_SLOW_SEL = 6;
  localparam int CFTC_POS_ISEL = 0;

  // Control three and hold field positions
  localparam int CFTC_POS_STEP = 5;
  localparam int CFTC_POS_HOLD = 0;

  // Reset values of the fields
  localparam logic [3:0] CFTC_RST_ISEL = 4'h6;
  localparam logic [3:0] CFTC_RST_TIMEOUT = 4'hB;
  localparam logic [2:0] CFTC_RST_EOC = 3'h0;
  localparam logic [1:0] CFTC_RST_STEP = 2'h0;

  // Current and time scaling
  localparam logic [9:0] CFTC_ISEL_STEP_MA = 10'h032;
  localparam logic [9:0] CFTC_EOC_BASE_MA = 10'h014;
  localparam logic [9:0] CFTC_EOC_STEP_MA = 10'h00A;
  localparam logic [9:0] CFTC_SLOW_LO_MA = 10'h032;
  localparam logic [9:0] CFTC_SLOW_HI_MA = 10'h064;
  localparam logic [14:0] CFTC_TIME_STEP_S = 15'h0708;
  localparam int CFTC_READ_SHIFT = 11;

  // Back-off step times in microseconds
  localparam logic [7:0] CFTC_STEP_US_0 = 8'h08;
  localparam logic [7:0] CFTC_STEP_US_1 = 8'h10;
  localparam logic [7:0] CFTC_STEP_US_2 = 8'h20;
  localparam logic [7:0] CFTC_STEP_US_3 = 8'h80;

  // Charger mode, coded as the status field reads
  typedef enum logic [1:0] {
    CFTC_OFF = 2'b00,
    CFTC_SLOW = 2'b01,
    CFTC_QUICK = 2'b10
  } cftc_state_type;

  // Analog-side conditions arriving from outside the clock domain
  typedef struct packed {
    logic supply_ok;
    logic batt_above_min;
    logic slow_ok;
    logic usb_limit_hit;
    logic temp_pause;
    logic maxcur_pause;
    logic fault;
    logic choke_on;
    logic [9:0] current_ma;
  } cftc_cond_type;

  // Charger commands sent to the analog side
  typedef struct packed {
    cftc_state_type mode;
    logic [9:0] current_limit_ma;
    logic throttle_active;
    logic [7:0] backoff_step_us;
  } cftc_drive_type;

endpackage

/* testbench/cftc_checker.sv */
// Purpose: Port-level checks of the charge timer controller
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Attached by bind; watches only the top module's ports
module cftc_checker #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register bus
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Charger side
  input wire cftc_pkg::cftc_cond_type i_cond,
  input wire cftc_pkg::cftc_drive_type o_drive
);
  import cftc_pkg::*;

  logic [7:0] idx; // Word index of the request
  logic mapped; // Index hits a register
  logic [3:0] qage_reg; // Cycles since quick enable was written

  assign idx = i_avs_address[9:2];
  assign mapped = idx inside {CFTC_IDX_IRQ_STATUS, CFTC_IDX_CTRL_ONE,
    CFTC_IDX_CTRL_TWO, CFTC_IDX_CTRL_THREE, CFTC_IDX_HOLD_CTRL};

  // Age of the last accepted quick-enable write, saturating
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      qage_reg <= 4'hF;
    else if (i_avs_write && !o_avs_waitrequest &&
             idx == CFTC_IDX_CTRL_ONE && i_avs_writedata[5])
      qage_reg <= 4'h0;
    else if (qage_reg != 4'hF)
      qage_reg <= qage_reg + 4'h1;
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  // A request the slave has not answered yet
  sequence s_req_open;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  // Fault seen long enough to pass the synchroniser
  sequence s_fault_held;
    i_cond.fault [*6];
  endsequence
  // Quick conditions missing long enough to be seen
  sequence s_unready_held;
    !(i_cond.supply_ok && i_cond.batt_above_min) [*6];
  endsequence

  a_answer_next: assert property (s_req_open |=> !o_avs_waitrequest)
    else $error("answer not one cycle after request");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_zero: assert property (o_avs_waitrequest |-> o_avs_readdata == 0)
    else $error("read data not zero outside answer");
  a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest &&
    !mapped |-> o_avs_readdata == 0)
    else $error("unmapped read not zero");
  a_step_legal: assert property ($past(i_rst_n) |->
    o_drive.backoff_step_us inside {8'h08, 8'h10, 8'h20, 8'h80})
    else $error("back-off step time not a legal value");
  a_no_auto_quick: assert property (o_drive.mode == CFTC_QUICK &&
    $past(o_drive.mode) == CFTC_SLOW |-> qage_reg < 4'hA)
    else $error("slow to quick without a write");
  a_fault_stops: assert property (s_fault_held |->
    o_drive.mode == CFTC_OFF)
    else $error("charging goes on during fault");
  a_quick_ready: assert property (s_unready_held |->
    o_drive.mode != CFTC_QUICK)
    else $error("quick charging without conditions");
endmodule

bind cftc_charge_timer_ctrl cftc_checker #(.TICK_CYCLES(TICK_CYCLES))
  cftc_checker_inst (
  .i_clock(i_clock),
  .i_rst_n(i_rst_n),
  .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .i_cond(i_cond),
  .o_drive(o_drive)
);

/* testbench/cftc_charge_timer_ctrl_bench.sv */
// Purpose: Register-level tests of the charge timer controller
// Assumes: One timer tick per clock so timeouts stay short
// Notes: Timer code 0 gives 3600 ticks; readback is ticks >> 11
module cftc_charge_timer_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cftc_pkg::*;

  logic i_clock = 1'b0; // Core clock
  logic i_rst_n = 1'b0; // Reset, active low
  logic [9:0] addr; // Bus address
  logic rd; // Read request
  logic wr; // Write request
  logic [31:0] wdata; // Write data
  logic [31:0] rdata; // Read data
  logic wait_q; // Waitrequest
  cftc_cond_type cond; // Analog conditions
  cftc_drive_type drive; // Charger commands
  logic [31:0] val; // Last read value
  logic [7:0] steps [4] = '{8'h08, 8'h10, 8'h20, 8'h80};
  logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h8, 4'hF};
  int n_errors = 0;
  int num_checks = 0;

  // Free-running 200 MHz clock
  always #2.5 i_clock = ~i_clock;

  cftc_charge_timer_ctrl #(.TICK_CYCLES(1)) cftc_charge_timer_ctrl_inst (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_avs_address(addr),
    .i_avs_read(rd),
    .i_avs_write(wr),
    .i_avs_writedata(wdata),
    .i_avs_byteenable(4'h3),
    .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_q),
    .i_cond(cond),
    .o_drive(drive)
  );

  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Case-equal compare; an unknown bit matches only an unknown bit
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle; the request is held until waitrequest is seen low
  task automatic bus(input logic is_rd, input logic [7:0] idx,
    input logic [31:0] wd, output logic [31:0] q);
    int n;
    @(posedge i_clock);
    rd <= is_rd;
    wr <= ~is_rd;
    addr <= {idx, 2'b00};
    wdata <= wd;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (wait_q !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20)
    begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic rd_reg(input logic [7:0] idx, output logic [31:0] q);
    bus(1'b1, idx, 32'h0, q);
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, idx, d, q);
  endtask

  // Bounded wait for a charger mode; a miss ends the run
  task automatic wait_mode(input cftc_state_type m, input int lim);
    int n;
    n = 0;
    while (drive.mode !== m && n < lim)
    begin
      @(posedge i_clock);
      n++;
    end
    chk({30'h0, drive.mode}, {30'h0, m});
    if (drive.mode !== m)
      end_of_test();
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // Main sequence
  initial
  begin
    addr = 10'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    cond = '0;
    cond.current_ma = 10'h1F4;
    idle(3);
    chk({24'h0, drive.backoff_step_us}, 32'h0);
    i_rst_n <= 1'b1;
    idle(2);
    chk({24'h0, drive.backoff_step_us}, 32'h8);
    rd_reg(CFTC_IDX_CTRL_ONE, val);
    chk(val, 32'h0);
    // Idle timer reads back 390 min as eleven 2048 s units
    rd_reg(CFTC_IDX_CTRL_TWO, val);
    chk(val & 32'h3FCF, 32'hB06);
    rd_reg(8'h40, val);
    chk(val, 32'h0);
    wr_reg(8'h40, 32'hFFFF);
    rd_reg(CFTC_IDX_IRQ_STATUS, val);
    chk(val, 32'h0);
    // Enable is refused while conditions are missing
    wr_reg(CFTC_IDX_CTRL_ONE, 32'h20);
    rd_reg(CFTC_IDX_CTRL_ONE, val);
    chk(val, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(CFTC_IDX_CTRL_THREE, 32'(k) << 5);
      idle(3);
      chk({24'h0, drive.backoff_step_us}, {24'h0, steps[k]});
    end
    // Shortest timeout, then slow charging starts
    wr_reg(CFTC_IDX_CTRL_TWO, 32'h6);
    cond.slow_ok <= 1'b1;
    wait_mode(CFTC_SLOW, 10);
    cond.supply_ok <= 1'b1;
    cond.batt_above_min <= 1'b1;
    idle(4);
    rd_reg(CFTC_IDX_IRQ_STATUS, val);
    chk(val & 32'h200, 32'h200);
    rd_reg(CFTC_IDX_IRQ_STATUS, val);
    chk(val & 32'h200, 32'h0);
    wr_reg(CFTC_IDX_CTRL_ONE, 32'h20);
    wait_mode(CFTC_QUICK, 10);
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(CFTC_IDX_CTRL_TWO, {28'h0, codes[k]});
      idle(3);
      chk({22'h0, drive.current_limit_ma}, codes[k] * 32'd50);
    end
    // Losing conditions falls back and never returns by itself
    cond.supply_ok <= 1'b0;
    wait_mode(CFTC_SLOW, 10);
    rd_reg(CFTC_IDX_CTRL_ONE, val);
    chk(val & 32'h20, 32'h0);
    cond.supply_ok <= 1'b1;
    idle(10);
    chk({30'h0, drive.mode}, {30'h0, CFTC_SLOW});
    chk({22'h0, drive.current_limit_ma}, 32'd50);
    // Hold freezes the timer; without it the readback would reach 0
    rd_reg(CFTC_IDX_CTRL_TWO, val);
    chk((val >> 8) & 32'hF, 32'h1);
    wr_reg(CFTC_IDX_HOLD_CTRL, 32'h1);
    idle(3000);
    chk({22'h0, drive.current_limit_ma}, 32'h0);
    rd_reg(CFTC_IDX_CTRL_TWO, val);
    chk((val >> 8) & 32'hF, 32'h1);
    wr_reg(CFTC_IDX_HOLD_CTRL, 32'h0);
    idle(1700);
    rd_reg(CFTC_IDX_CTRL_TWO, val);
    chk((val >> 8) & 32'hF, 32'h0);
    wait_mode(CFTC_OFF, 2500);
    rd_reg(CFTC_IDX_IRQ_STATUS, val);
    chk(val & 32'h800, 32'h800);
    // Low current with choking on must not end charging
    cond.choke_on <= 1'b1;
    cond.current_ma <= 10'h00F;
    wr_reg(CFTC_IDX_CTRL_ONE, 32'h0);
    wait_mode(CFTC_SLOW, 20);
    idle(20);
    rd_reg(CFTC_IDX_IRQ_STATUS, val);
    chk(val & 32'h400, 32'h0);
    // Run-on action goes in before detection comes back
    wr_reg(CFTC_IDX_CTRL_ONE, 32'h40);
    cond.choke_on <= 1'b0;
    idle(10);
    rd_reg(CFTC_IDX_IRQ_STATUS, val);
    chk(val & 32'h400, 32'h400);
    chk({30'h0, drive.mode}, {30'h0, CFTC_SLOW});
    // Threshold 20mA keeps 25mA going, 90mA stops 85mA
    cond.current_ma <= 10'h019;
    wr_reg(CFTC_IDX_CTRL_ONE, 32'h0);
    idle(10);
    chk({30'h0, drive.mode}, {30'h0, CFTC_SLOW});
    cond.current_ma <= 10'h055;
    wr_reg(CFTC_IDX_CTRL_ONE, 32'h1C00);
    wait_mode(CFTC_OFF, 10);
    // Fault ends charging
    cond.current_ma <= 10'h1F4;
    wr_reg(CFTC_IDX_CTRL_ONE, 32'h0);
    wait_mode(CFTC_SLOW, 10);
    cond.fault <= 1'b1;
    wait_mode(CFTC_OFF, 10);
    cond.fault <= 1'b0;
    idle(4);
    // USB limit: 400mA at most, regulated with back-off, else ends
    wr_reg(CFTC_IDX_CTRL_TWO, 32'h8);
    wr_reg(CFTC_IDX_CTRL_ONE, 32'h30);
    wait_mode(CFTC_QUICK, 20);
    chk({22'h0, drive.current_limit_ma}, 32'd400);
    cond.usb_limit_hit <= 1'b1;
    idle(10);
    chk({30'h0, drive.mode}, {30'h0, CFTC_QUICK});
    chk({31'h0, drive.throttle_active}, 32'h1);
    wr_reg(CFTC_IDX_CTRL_ONE, 32'h20);
    wait_mode(CFTC_OFF, 10);
    end_of_test();
  end
endmodule
